// file: dv/fsps_cpu_model.sv
`timescale 1ns/100ps
module fsps_cpu_model import fsps_pkg::*; (
   // clock and eeprom status
   input wire logic ref_clk,
   input wire logic eeprom_write_busy,
   // register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // instruction side
   output logic spm_exec,
   output logic lpm_exec,
   output logic [15:0] z_ptr,
   output logic [15:0] data_word
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      spm_exec = 1'b0;
      lpm_exec = 1'b0;
      z_ptr = 16'h0000;
      data_word = 16'h0000;
   end
   // one-cycle register write
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data taken only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // control write, then store or load after gap cycles
   task cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] d,
            input int gap, input logic lpm, input logic wait_ee);
      while (wait_ee && eeprom_write_busy) @(posedge ref_clk);
      @(posedge ref_clk);
      z_ptr <= z;
      data_word <= d;
      wr(CTRL_ADDR, c);
      repeat (gap - 1) @(posedge ref_clk);
      if (lpm) begin
         lpm_exec <= 1'b1;
      end else begin
         spm_exec <= 1'b1;
      end
      @(posedge ref_clk);
      spm_exec <= 1'b0;
      lpm_exec <= 1'b0;
      // pointer reused at once: the op must have latched it
      z_ptr <= ~z;
      data_word <= ~d;
   endtask
endmodule

// file: dv/test_fsps_sequencer.sv
`timescale 1ns/100ps
module test_fsps_sequencer import fsps_pkg::*;;
   localparam int OP_LEN = 20;
   typedef struct {logic [15:0] z; int gap; logic [7:0] e;} fsps_row_t;
   logic ref_clk, rst_b, por_b, reg_wr, reg_rd, spm_exec, lpm_exec, lpm_ovr;
   logic cpu_halt, rww_read_block, int_req, eeprom_write_busy, eeprom_wr_start;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, lpm_data, low_fuse_byte;
   logic [7:0] high_fuse_byte, fl_page, q;
   logic [15:0] z_ptr, data_word, fl_rd_data;
   logic [2:0] extended_fuse_byte;
   logic [5:0] lock_init, lock_bits, fl_rd_idx;
   logic [1:0] fl_op;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   // fuse and lock reads: pointer, lpm gap, expected byte
   fsps_row_t rows [4] = '{'{16'h0000, 1, 8'hA5}, '{16'h0001, 2, 8'hED},
                          '{16'h0002, 3, 8'hFD}, '{16'h0003, 1, 8'h3C}};
   fsps_sequencer #(.OP_LEN(OP_LEN)) fsps_sequencer_i (.ref_clk, .rst_b, .por_b,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .spm_exec, .lpm_exec,
      .z_ptr, .data_word, .lpm_ovr, .lpm_data, .cpu_halt, .rww_read_block,
      .int_req, .eeprom_write_busy, .eeprom_wr_start, .low_fuse_byte,
      .high_fuse_byte, .extended_fuse_byte, .lock_init, .lock_bits, .fl_op,
      .fl_page, .fl_rd_idx, .fl_rd_data);
   fsps_cpu_model fsps_cpu_model_i (.ref_clk, .eeprom_write_busy, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .spm_exec, .lpm_exec, .z_ptr,
      .data_word);
   always #25 ref_clk = ~ref_clk;
   // hang guard, far above the whole sequence
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task load(input logic [5:0] i, input logic [15:0] d);
      fsps_cpu_model_i.cmd(8'h01, {9'h000, i, 1'b0}, d, 1, 1'b0, 1'b1);
   endtask
   // buffer slot seen by the flash side
   task peek(input logic [5:0] i, input logic [15:0] e);
      @(posedge ref_clk);
      fl_rd_idx <= i;
      repeat (2) @(posedge ref_clk);
      #1 chk(fl_rd_data, e);
   endtask
   // op length in cycles it shows; n0 counts those already gone by
   task run(input int n0);
      n = n0;
      while (fl_op !== 2'h0 && n < 100) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk(16'(n >= OP_LEN && n <= OP_LEN * 45 / 37), 16'h0001);
   endtask
   task op_seen(input logic [1:0] op, input logic [7:0] pg, input logic h, input logic b);
      @(posedge ref_clk);
      #1 chk(16'(fl_op), 16'(op));
      chk(16'(fl_page), 16'(pg));
      chk(16'(cpu_halt), 16'(h));
      chk(16'(rww_read_block), 16'(b));
   endtask
   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      por_b = 1'b0;
      fl_rd_idx = 6'h00;
      eeprom_write_busy = 1'b0;
      eeprom_wr_start = 1'b0;
      low_fuse_byte = 8'hA5;
      high_fuse_byte = 8'h3C;
      extended_fuse_byte = 3'h5;
      lock_init = 6'h2D;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      fsps_cpu_model_i.rd(8'h37, q);
      chk(16'(q), 16'h0000);
      chk(16'(lock_bits), 16'h002D);
      chk(16'(int_req), 16'h0000);
      // read-only bits ignore writes; unmapped address reads zero
      fsps_cpu_model_i.wr(8'h37, 8'hE0);
      fsps_cpu_model_i.rd(8'h37, q);
      chk(16'(q), 16'h0080);
      chk(16'(int_req), 16'h0001);
      fsps_cpu_model_i.wr(8'h37, 8'h00);
      fsps_cpu_model_i.rd(8'h36, q);
      chk(16'(q), 16'h0000);
      foreach (rows[i]) begin
         fsps_cpu_model_i.cmd(8'h09, rows[i].z, 16'h0000, rows[i].gap, 1'b1, 1'b1);
         #1 chk(16'(lpm_ovr), 16'h0001);
         chk(16'(lpm_data), 16'(rows[i].e));
         fsps_cpu_model_i.rd(8'h37, q);
         chk(16'(q), 16'h0000);
      end
      // load one past the three-cycle window
      fsps_cpu_model_i.cmd(8'h09, 16'h0000, 16'h0000, 4, 1'b1, 1'b1);
      #1 chk(16'(lpm_ovr), 16'h0000);
      load(6'h05, 16'h1234);
      peek(6'h05, 16'h1234);
      // erase rewritable page 3, junk word bits, store at last window cycle
      fsps_cpu_model_i.cmd(8'h83, 16'h01BE, 16'hDEAD, 4, 1'b0, 1'b1);
      op_seen(2'h1, 8'h03, 1'b0, 1'b1);
      run(1);
      fsps_cpu_model_i.rd(8'h37, q);
      chk(16'(q), 16'h00C0);
      chk(16'(int_req), 16'h0001);
      chk(16'(rww_read_block), 16'h0001);
      load(6'h06, 16'h0606);
      fsps_cpu_model_i.rd(8'h37, q);
      chk(16'(q), 16'h0000);
      peek(6'h06, 16'h0606);
      fsps_cpu_model_i.wr(8'h37, 8'h11);
      repeat (6) @(posedge ref_clk);
      chk(16'(rww_read_block), 16'h0000);
      peek(6'h06, 16'hFFFF);
      // page write into the fixed section halts the cpu
      load(6'h02, 16'hBEEF);
      fsps_cpu_model_i.cmd(8'h05, 16'h7300, 16'h0000, 2, 1'b0, 1'b1);
      op_seen(2'h2, 8'hE6, 1'b1, 1'b1);
      run(1);
      chk(16'(cpu_halt), 16'h0000);
      peek(6'h02, 16'hFFFF);
      // erase in the fixed section halts the cpu but sets no busy flag
      fsps_cpu_model_i.cmd(8'h03, 16'h7300, 16'h0000, 1, 1'b0, 1'b1);
      op_seen(2'h1, 8'hE6, 1'b1, 1'b1);
      run(1);
      chk(16'(cpu_halt), 16'h0000);
      fsps_cpu_model_i.rd(8'h37, q);
      chk(16'(q), 16'h0000);
      chk(16'(rww_read_block), 16'h0000);
      // lock value with recommended pointer and top bits
      fsps_cpu_model_i.cmd(8'h09, 16'h0001, 16'h00F6, 3, 1'b0, 1'b1);
      op_seen(2'h3, 8'h00, 1'b0, 1'b0);
      run(1);
      chk(16'(lock_bits), 16'h0024);
      // eeprom write in progress refuses stores and fuse reads
      eeprom_write_busy <= 1'b1;
      fsps_cpu_model_i.cmd(8'h03, 16'h0080, 16'h0000, 1, 1'b0, 1'b0);
      #1 chk(16'(fl_op), 16'h0000);
      fsps_cpu_model_i.cmd(8'h09, 16'h0000, 16'h0000, 1, 1'b1, 1'b0);
      #1 chk(16'(lpm_ovr), 16'h0000);
      eeprom_write_busy <= 1'b0;
      repeat (6) @(posedge ref_clk);
      load(6'h07, 16'h5555);
      eeprom_wr_start <= 1'b1;
      @(posedge ref_clk);
      eeprom_wr_start <= 1'b0;
      peek(6'h07, 16'hFFFF);
      // store too late: window has closed
      fsps_cpu_model_i.cmd(8'h03, 16'h0080, 16'h0000, 5, 1'b0, 1'b1);
      #1 chk(16'(fl_op), 16'h0000);
      fsps_cpu_model_i.rd(8'h37, q);
      chk(16'(q), 16'h0000);
      // system reset in mid-erase must not stop it
      load(6'h09, 16'h0909);
      fsps_cpu_model_i.cmd(8'h03, 16'h0080, 16'h0000, 1, 1'b0, 1'b1);
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1 chk(16'(fl_op), 16'h0001);
      peek(6'h09, 16'hFFFF);
      run(8);
      conclude();
   end
endmodule

// file: logic/fsps_op_timer.sv
`timescale 1ns/100ps
module fsps_op_timer import fsps_pkg::*; #(
   parameter int CYCLES = OP_CYCLES
) (
   // clock and power-on reset
   input wire logic ref_clk,
   input wire logic por_b,
   // control
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_ff;
   logic run_ff;
   logic done_ff;

   // runs off power-on reset so system reset cannot cut a write short
   always_ff @(posedge ref_clk or negedge por_b) begin
      if (!por_b) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start && !run_ff) begin
            run_ff <= 1'b1;
            cnt_ff <= '0;
         end else if (run_ff) begin
            if (cnt_ff == LAST) begin
               run_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
      end
   end

   assign busy = run_ff;
   assign done = done_ff;

   a_op_span: assert property (@(posedge ref_clk) disable iff (!por_b)
      done_ff |-> $past(cnt_ff) == LAST)
      else $error("operation ended before its full count");
endmodule

// file: logic/fsps_page_buf.sv
`timescale 1ns/100ps
module fsps_page_buf import fsps_pkg::*; #(
   parameter int WORDS = 64,
   parameter int W = 16,
   parameter int IW = 6
) (
   // clock and system reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // load and clear
   input wire logic clr,
   input wire logic ld,
   input wire logic [IW-1:0] ld_idx,
   input wire logic [W-1:0] ld_data,
   // flash read side
   input wire logic [IW-1:0] rd_idx,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [WORDS];
   logic [WORDS-1:0] valid_ff;
   logic [W-1:0] rd_data_ff;

   // one slot per word; an unloaded slot reads as erased flash
   for (genvar gi = 0; gi < WORDS; gi++) begin : g_slot
      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            valid_ff[gi] <= 1'b0;
         end else if (clr) begin
            valid_ff[gi] <= 1'b0;
         end else if (ld && ld_idx == IW'(gi)) begin
            valid_ff[gi] <= 1'b1;
         end
      end
      // no reset on data: valid bit alone says if it counts
      always_ff @(posedge ref_clk) begin
         if (ld && ld_idx == IW'(gi)) begin
            mem[gi] <= ld_data;
         end
      end
   end

   // registered read toward the flash array
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_ff <= ERASED_WORD;
      end else begin
         rd_data_ff <= valid_ff[rd_idx] ? mem[rd_idx] : ERASED_WORD;
      end
   end

   assign rd_data = rd_data_ff;

   a_buf_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clr |=> valid_ff == '0)
      else $error("page buffer not cleared");
endmodule

// file: logic/fsps_pkg.sv
// How it works
// - erase on code X0000011 plus store
// - erase halts cpu only for fixed section
// - load stores data word at word index
// - buffer cleared by write, read enable, reset
// - eeprom write discards loaded words
// - page write on code X0000101 plus store
// - page write halts cpu only for fixed
// - interrupt held while enable bit clear
// - rewritable reads blocked during erase/write
// - busy flag stays until read enable or page load
// - lock program from r0 bits 5:0
// - lock programming keeps whole flash readable
// - eeprom write refuses programming, fuse reads
// - load within three cycles returns lock
// - enable bits clear on read or timeout
// - pointer selects low, extended, high fuse
// - programmed bits read zero, else one
// - write finishes across system reset
// - operations last 3.7 to 4.5 ms
// - control register layout, reset zero
// - page index z14:7, word z6:1
// - new page load clears busy flag
package fsps_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'h37;
   localparam int BIT_IE = 7;
   localparam int BIT_BUSY = 6;
   localparam int BIT_RRE = 4;
   localparam int BIT_SELF_PROGRAM_ENABLE = 0;
   localparam logic [4:0] CMD_LOAD = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_LOCK = 5'h09;
   localparam logic [4:0] CMD_NONE = 5'h00;
   localparam logic [2:0] SPM_WIN = 3'h4;
   localparam logic [2:0] LPM_WIN = 3'h3;
   localparam int CLK_PERIOD_NS = 50;
   localparam int OP_MIN_NS = 3700000;
   localparam int OP_MAX_NS = 4500000;
   localparam int OP_CYCLES = (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PAGE_MSB = 14;
   localparam int PAGE_LSB = 7;
   localparam int WORD_MSB = 6;
   localparam int WORD_LSB = 1;
   localparam logic [15:0] Z_FUSE_LO = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
   localparam logic [15:0] Z_FUSE_HI = 16'h0003;
   localparam logic [1:0] LOCK_PAD = 2'h3;
   localparam logic [4:0] EXT_PAD = 5'h1F;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_ERASE = 2'b01,
      OP_WRITE = 2'b10,
      OP_LOCK = 2'b11
   } fsps_op_t;
endpackage

// file: logic/fsps_sequencer.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
module fsps_sequencer import fsps_pkg::*; #(
   parameter int OP_LEN = OP_CYCLES,
   parameter int RWW_PAGES = 224,
   parameter int WORDS = 64
) (
   // clock and resets
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic por_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu instruction side
   input wire logic spm_exec,
   input wire logic lpm_exec,
   input wire logic [15:0] z_ptr,
   input wire logic [15:0] data_word,
   output logic lpm_ovr,
   output logic [7:0] lpm_data,
   output logic cpu_halt,
   output logic rww_read_block,
   output logic int_req,
   // eeprom interlock
   input wire logic eeprom_write_busy,
   input wire logic eeprom_wr_start,
   // fuse and lock values
   input wire logic [7:0] low_fuse_byte,
   input wire logic [7:0] high_fuse_byte,
   input wire logic [2:0] extended_fuse_byte,
   input wire logic [5:0] lock_init,
   output logic [5:0] lock_bits,
   // flash array side
   output logic [1:0] fl_op,
   output logic [7:0] fl_page,
   input wire logic [5:0] fl_rd_idx,
   output logic [15:0] fl_rd_data
);
   localparam logic [7:0] RWW_LIMIT = 8'(RWW_PAGES);

   // control register fields
   logic ie_ff;
   logic busy_ff;
   logic [4:0] cmd_ff;
   logic [2:0] win_ff;
   logic [7:0] reg_rdata_ff;
   logic lpm_ovr_ff;
   logic [7:0] lpm_data_ff;
   logic int_req_ff;
   logic block_ff;
   logic nxt_ie;
   logic nxt_busy;
   logic [4:0] nxt_cmd;
   logic [2:0] nxt_win;

   // operation state, kept on power-on reset
   fsps_op_t op_ff;
   logic [7:0] page_ff;
   logic halt_ff;
   logic tgt_rww_ff;
   logic [5:0] lock_ff;
   logic [5:0] lock_val_ff;
   logic lock_loaded_ff;

   // decode
   logic ctrl_wr;
   logic ctrl_rd;
   logic op_idle;
   logic spm_ok;
   logic spm_load;
   logic spm_erase;
   logic spm_write;
   logic spm_lock;
   logic op_start;
   logic lpm_ok;
   logic lpm_acc;
   logic win_expire;
   logic rre_wr;
   logic buf_clr;
   logic op_busy;
   logic op_done;
   logic [7:0] z_page;
   logic z_in_rww;
   logic [7:0] nxt_lpm_data;

   assign ctrl_wr = reg_wr && reg_addr == CTRL_ADDR;
   assign ctrl_rd = reg_rd && reg_addr == CTRL_ADDR;
   assign op_idle = op_ff == OP_IDLE;
   assign z_page = z_ptr[PAGE_MSB:PAGE_LSB];
   assign z_in_rww = z_page < RWW_LIMIT;

   // a store is only taken inside the window and never during eeprom writes
   assign spm_ok = spm_exec && win_ff != 3'h0 && op_idle && !eeprom_write_busy;
   assign spm_load = spm_ok && cmd_ff == CMD_LOAD;
   assign spm_erase = spm_ok && cmd_ff == CMD_ERASE;
   assign spm_write = spm_ok && cmd_ff == CMD_WRITE;
   assign spm_lock = spm_ok && cmd_ff == CMD_LOCK;
   assign op_start = spm_erase || spm_write || spm_lock;

   // the load window is the first three cycles of the store window
   assign lpm_ok = win_ff > (SPM_WIN - LPM_WIN);
   assign lpm_acc = lpm_exec && lpm_ok && cmd_ff == CMD_LOCK && !eeprom_write_busy;
   assign win_expire = win_ff == 3'h1 && !spm_ok && !lpm_acc;
   assign rre_wr = ctrl_wr && reg_wdata[BIT_RRE] && op_idle;

   // write done, read enable and an eeprom write all empty the buffer
   assign buf_clr = (op_done && op_ff == OP_WRITE) || rre_wr || eeprom_wr_start;

   // next value of the control register
   always_comb begin
      nxt_ie = ie_ff;
      nxt_busy = busy_ff;
      nxt_cmd = cmd_ff;
      nxt_win = (win_ff != 3'h0) ? win_ff - 3'h1 : 3'h0;
      if (ctrl_wr) begin
         nxt_ie = reg_wdata[BIT_IE];
         if (op_idle && !op_start) begin
            nxt_cmd = reg_wdata[4:0];
            nxt_win = reg_wdata[BIT_SELF_PROGRAM_ENABLE] ? SPM_WIN : 3'h0;
         end
      end
      if (rre_wr) begin
         nxt_busy = 1'b0;
      end
      if (spm_load) begin
         nxt_cmd = CMD_NONE;
         nxt_busy = 1'b0;
         nxt_win = 3'h0;
      end
      if (op_start) begin
         nxt_win = 3'h0;
      end
      if ((spm_erase || spm_write) && z_in_rww) begin
         nxt_busy = 1'b1;
      end
      if (lpm_acc || win_expire) begin
         nxt_cmd = CMD_NONE;
         nxt_win = 3'h0;
      end
      if (op_done) begin
         nxt_cmd = CMD_NONE;
      end
   end

   // control register, cleared by system reset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ie_ff <= 1'b0;
         busy_ff <= 1'b0;
         cmd_ff <= CMD_NONE;
         win_ff <= 3'h0;
      end else begin
         ie_ff <= nxt_ie;
         busy_ff <= nxt_busy;
         cmd_ff <= nxt_cmd;
         win_ff <= nxt_win;
      end
   end

   // register read, one cycle after the strobe; reserved bit reads zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= 8'h00;
      end else if (ctrl_rd) begin
         reg_rdata_ff <= {ie_ff, busy_ff, 1'b0, cmd_ff};
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end

   // interrupt and read blocking follow next state, so no cycle of lag
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_req_ff <= 1'b0;
         block_ff <= 1'b0;
      end else begin
         int_req_ff <= nxt_ie && !nxt_cmd[BIT_SELF_PROGRAM_ENABLE];
         // any erase or write blocks the rewritable side, even one aimed at
         // the fixed section while the cpu is halted
         block_ff <= nxt_busy || spm_erase || spm_write
            || (op_busy && op_ff != OP_LOCK);
      end
   end

   // fuse and lock read-back; bits arrive with programmed as zero
   always_comb begin
      case (z_ptr)
         Z_FUSE_LO: nxt_lpm_data = low_fuse_byte;
         Z_LOCK: nxt_lpm_data = {LOCK_PAD, lock_ff};
         Z_FUSE_EXT: nxt_lpm_data = {EXT_PAD, extended_fuse_byte};
         Z_FUSE_HI: nxt_lpm_data = high_fuse_byte;
         default: nxt_lpm_data = 8'hFF;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lpm_ovr_ff <= 1'b0;
         lpm_data_ff <= 8'h00;
      end else begin
         lpm_ovr_ff <= lpm_acc;
         if (lpm_acc) begin
            lpm_data_ff <= nxt_lpm_data;
         end
      end
   end

   // operation state lives on power-on reset: a running write survives
   // a system reset as long as the supply holds
   always_ff @(posedge ref_clk or negedge por_b) begin
      if (!por_b) begin
         op_ff <= OP_IDLE;
         page_ff <= 8'h00;
         halt_ff <= 1'b0;
         tgt_rww_ff <= 1'b0;
         lock_val_ff <= 6'h3F;
      end else if (op_start) begin
         page_ff <= z_page;
         tgt_rww_ff <= z_in_rww;
         lock_val_ff <= data_word[5:0];
         if (spm_erase) begin
            op_ff <= OP_ERASE;
            halt_ff <= !z_in_rww;
         end else if (spm_write) begin
            op_ff <= OP_WRITE;
            halt_ff <= !z_in_rww;
         end else begin
            op_ff <= OP_LOCK;
            halt_ff <= 1'b0;
         end
      end else if (op_done) begin
         op_ff <= OP_IDLE;
         halt_ff <= 1'b0;
      end
   end

   // lock bits: strap caught after release, then only ever programmed
   always_ff @(posedge ref_clk or negedge por_b) begin
      if (!por_b) begin
         lock_ff <= 6'h3F;
         lock_loaded_ff <= 1'b0;
      end else if (!lock_loaded_ff) begin
         lock_ff <= lock_init;
         lock_loaded_ff <= 1'b1;
      end else if (op_done && op_ff == OP_LOCK) begin
         lock_ff <= lock_ff & lock_val_ff;
      end
   end

   fsps_op_timer #(
      .CYCLES(OP_LEN)
   ) u_timer (
      .ref_clk(ref_clk),
      .por_b(por_b),
      .start(op_start),
      .busy(op_busy),
      .done(op_done)
   );

   // word loads ignore the pointer's page bits
   fsps_page_buf #(
      .WORDS(WORDS),
      .W(16),
      .IW(6)
   ) u_buf (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clr(buf_clr),
      .ld(spm_load),
      .ld_idx(z_ptr[WORD_MSB:WORD_LSB]),
      .ld_data(data_word),
      .rd_idx(fl_rd_idx),
      .rd_data(fl_rd_data)
   );

   assign reg_rdata = reg_rdata_ff;
   assign lpm_ovr = lpm_ovr_ff;
   assign lpm_data = lpm_data_ff;
   assign cpu_halt = halt_ff;
   assign rww_read_block = block_ff;
   assign int_req = int_req_ff;
   assign lock_bits = lock_ff;
   assign fl_op = op_ff;
   assign fl_page = page_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b || !por_b);

   sequence s_arm;
      ctrl_wr && reg_wdata[BIT_SELF_PROGRAM_ENABLE] && op_idle && !spm_ok && !lpm_acc;
   endsequence
   sequence s_quiet4;
      (!spm_exec && !lpm_exec && !ctrl_wr)[*4];
   endsequence

   a_int_level: assert property ((ie_ff && !cmd_ff[BIT_SELF_PROGRAM_ENABLE] && !ctrl_wr
      && !op_start && !lpm_acc && !win_expire) |=> int_req)
      else $error("ready interrupt missing while enable bit clear");
   a_window_close: assert property (s_arm ##1 s_quiet4 |=>
      !cmd_ff[BIT_SELF_PROGRAM_ENABLE])
      else $error("enable bit survived an unused window");
   a_load_clears: assert property (spm_load && !ctrl_wr |=>
      !busy_ff && !cmd_ff[BIT_SELF_PROGRAM_ENABLE])
      else $error("page load left busy or enable set");
   a_erase_halt: assert property (spm_erase && !z_in_rww |=>
      cpu_halt && fl_op == OP_ERASE)
      else $error("fixed section erase did not halt cpu");
   a_lock_open: assert property (op_ff == OP_LOCK |->
      !cpu_halt && !block_ff)
      else $error("lock programming blocked flash reads");
   a_busy_block: assert property (busy_ff |-> rww_read_block)
      else $error("rewritable section readable while busy");
   a_lock_read: assert property (lpm_acc && z_ptr == Z_LOCK |=>
      lpm_ovr && lpm_data == {LOCK_PAD, $past(lock_ff)})
      else $error("lock byte not returned");
   a_eeprom_refuse: assert property (op_idle && eeprom_write_busy |=>
      fl_op == OP_IDLE && !lpm_ovr)
      else $error("programming accepted during eeprom write");
   a_done_clear: assert property (op_done && !ctrl_wr |=>
      !cmd_ff[BIT_SELF_PROGRAM_ENABLE] && fl_op == OP_IDLE)
      else $error("enable bit still set after operation");
   a_busy_set: assert property ((spm_erase || spm_write) && z_in_rww |=>
      busy_ff && rww_read_block)
      else $error("busy flag not raised by rewritable operation");
   a_reenable_clear: assert property (rre_wr && !spm_erase && !spm_write |=>
      !busy_ff)
      else $error("busy flag survived a read enable write");
   a_span_block: assert property (op_busy && op_ff != OP_LOCK |=>
      rww_read_block)
      else $error("rewritable section readable during erase or write");
   a_fixed_halt: assert property (op_busy && op_ff != OP_LOCK && !tgt_rww_ff |->
      cpu_halt)
      else $error("cpu not halted during fixed section operation");
   a_late_store: assert property (spm_exec && win_ff == 3'h0 && op_idle |=>
      fl_op == OP_IDLE)
      else $error("store outside the window started an operation");
   a_ext_fuse_pad: assert property (lpm_acc && z_ptr == Z_FUSE_EXT |=>
      lpm_data == {EXT_PAD, $past(extended_fuse_byte)})
      else $error("extended fuse byte returned wrongly");
endmodule
